/* File: hw/sap_pkg.sv */
// Constants and types of the serial conversion port
package sap_pkg;
    localparam int         RES_W      = 12;
    localparam int         FIFO_W     = 13;
    localparam int         FIFO_DEPTH = 8;
    localparam logic [4:0] EDGE_PD_LO = 5'h03;
    localparam logic [4:0] EDGE_MSB   = 5'h04;
    localparam logic [4:0] EDGE_TRACK = 5'h0E;
    localparam logic [4:0] EDGE_SUB0  = 5'h0F;
    localparam logic [4:0] EDGE_LAST  = 5'h10;
    localparam logic [11:0] SAR_INIT  = 12'h800;
    localparam int         CLK_NS     = 4;
    localparam int         ACQUIRE_INTERVAL_NS = 125;
    localparam int         ACQ_CYC    = (ACQUIRE_INTERVAL_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [5:0] ACQ_CYC_W  = 6'(ACQ_CYC);

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_DONE = 2'b10
    } sap_state_t;

    typedef enum logic [1:0]
    {
        PD_NONE    = 2'b00,
        PD_PARTIAL = 2'b01,
        PD_FULL    = 2'b10
    } sap_pd_t;
endpackage

/* File: hw/sap_fifo_if.sv */
// Interface carrying results into and out of the result FIFO
`timescale 1ns/10ps
`default_nettype none
interface sap_fifo_if
#(
    parameter int W = 13
);
    logic         push_valid;
    logic         push_ready;
    logic [W-1:0] push_data;
    logic         pop_valid;
    logic         pop_ready;
    logic [W-1:0] pop_data;

    modport fifo_mp
    (
        input  push_valid,
        input  push_data,
        input  pop_ready,
        output push_ready,
        output pop_valid,
        output pop_data
    );
    modport user_mp
    (
        output push_valid,
        output push_data,
        output pop_ready,
        input  push_ready,
        input  pop_valid,
        input  pop_data
    );
endinterface
`default_nettype wire

/* File: hw/sap_fifo.sv */
// Result FIFO built from flip-flops
`timescale 1ns/10ps
`default_nettype none
module sap_fifo
#(
    parameter int W = 13,
    parameter int D = 8
)
(
    input  wire logic   clk_sys,
    input  wire logic   reset,
    sap_fifo_if.fifo_mp f
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_q [D];
    logic [AW:0]  wr_ptr_q;
    logic [AW:0]  rd_ptr_q;
    logic         full;
    logic         empty;

    assign empty        = (wr_ptr_q == rd_ptr_q);
    assign full         = ((wr_ptr_q ^ rd_ptr_q) == {1'b1, {AW{1'b0}}});
    assign f.push_ready = !full;
    assign f.pop_valid  = !empty;
    assign f.pop_data   = mem_q[rd_ptr_q[AW-1:0]];

    always_ff @(posedge clk_sys)
    begin
        if (f.push_valid && !full)
        begin
            mem_q[wr_ptr_q[AW-1:0]] <= f.push_data;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            wr_ptr_q <= '0;
        end
        else if (f.push_valid && !full)
        begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            rd_ptr_q <= '0;
        end
        else if (f.pop_ready && !empty)
        begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: hw/sap_port.sv */
// Serial conversion and readout port of a 12-bit successive-approximation converter
`timescale 1ns/10ps
`default_nettype none
module sap_port
(
    input  wire logic                       clk_sys,
    input  wire logic                       reset,
    input  wire logic                       sclk_i,
    input  wire logic                       conv_start_n,
    input  wire logic                       cmp_i,
    output logic                            sdo_o,
    output logic                            sdo_oe,
    output logic                            track_o,
    output logic [sap_pkg::RES_W-1:0]       dac_code_o,
    output logic                            pd_partial_o,
    output logic                            pd_full_o,
    output logic                            acq_short_o,
    output logic                            overrun_o,
    output logic                            result_valid_o,
    output logic [sap_pkg::FIFO_W-1:0]      result_data_o,
    input  wire logic                       result_ready_i
);
    function automatic logic [3:0] bit_index(input logic [4:0] n);
        bit_index = 4'(sap_pkg::EDGE_SUB0 - n);
    endfunction

    logic [2:0]               sclk_s_q;
    logic [2:0]               cnv_s_q;
    logic [1:0]               cmp_s_q;
    logic                     sclk_rise;
    logic                     sclk_fall;
    logic                     cnv_fall;
    logic                     cnv_rise;
    logic                     start;
    logic                     pd_entry;
    logic                     pd_exit;
    sap_pkg::sap_state_t      state_q;
    sap_pkg::sap_pd_t         pd_q;
    logic [4:0]               cnt_q;
    logic                     rel_pend_q;
    logic                     sdo_q;
    logic                     oe_q;
    logic                     track_q;
    logic [sap_pkg::RES_W-1:0] code_q;
    logic                     first_q;
    logic                     push_valid_q;
    logic [sap_pkg::FIFO_W-1:0] push_data_q;
    logic                     overrun_q;
    logic [5:0]               acq_cnt_q;
    logic                     acq_short_q;
    logic                     res_valid_q;
    logic [sap_pkg::FIFO_W-1:0] res_data_q;

    sap_fifo_if #(.W(sap_pkg::FIFO_W)) fif ();

    sap_fifo
    #(
        .W (sap_pkg::FIFO_W),
        .D (sap_pkg::FIFO_DEPTH)
    )
    u_fifo
    (
        .clk_sys (clk_sys),
        .reset   (reset),
        .f       (fif.fifo_mp)
    );

    // Pins pass two flip-flops; the third stage only serves edge detection
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            sclk_s_q <= 3'h0;
            cnv_s_q  <= 3'h7;
            cmp_s_q  <= 2'h0;
        end
        else
        begin
            sclk_s_q <= {sclk_s_q[1:0], sclk_i};
            cnv_s_q  <= {cnv_s_q[1:0], conv_start_n};
            cmp_s_q  <= {cmp_s_q[0], cmp_i};
        end
    end

    assign sclk_rise = sclk_s_q[1] && !sclk_s_q[2];
    assign sclk_fall = !sclk_s_q[1] && sclk_s_q[2];
    assign cnv_fall  = !cnv_s_q[1] && cnv_s_q[2];
    assign cnv_rise  = cnv_s_q[1] && !cnv_s_q[2];
    assign start     = cnv_fall && (state_q != sap_pkg::ST_CONV);
    assign pd_entry  = (state_q == sap_pkg::ST_CONV) && cnv_rise
                       && (cnt_q >= sap_pkg::EDGE_PD_LO) && (cnt_q < sap_pkg::EDGE_TRACK);
    assign pd_exit   = cnv_rise && (((state_q == sap_pkg::ST_CONV)
                       && (cnt_q >= sap_pkg::EDGE_TRACK)) || (state_q == sap_pkg::ST_DONE));

    // Frame sequencing and output enable
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_q    <= sap_pkg::ST_IDLE;
            cnt_q      <= 5'h00;
            rel_pend_q <= 1'b0;
            oe_q       <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                sap_pkg::ST_IDLE, sap_pkg::ST_DONE:
                begin
                    if (start)
                    begin
                        state_q    <= sap_pkg::ST_CONV;
                        cnt_q      <= 5'h00;
                        rel_pend_q <= 1'b0;
                        oe_q       <= 1'b1;
                    end
                    else if (state_q == sap_pkg::ST_DONE)
                    begin
                        if (cnv_rise || (sclk_rise && rel_pend_q))
                        begin
                            state_q <= sap_pkg::ST_IDLE;
                            oe_q    <= 1'b0;
                        end
                        else if (sclk_fall && !cnv_s_q[1])
                        begin
                            rel_pend_q <= 1'b1;
                        end
                    end
                end
                sap_pkg::ST_CONV:
                begin
                    if (cnv_rise && (cnt_q < sap_pkg::EDGE_TRACK))
                    begin
                        state_q <= sap_pkg::ST_IDLE;
                        oe_q    <= 1'b0;
                    end
                    else if (sclk_rise)
                    begin
                        cnt_q <= cnt_q + 5'h01;
                        if (cnt_q == sap_pkg::EDGE_SUB0)
                        begin
                            state_q <= sap_pkg::ST_DONE;
                        end
                    end
                end
                default:
                begin
                    state_q <= sap_pkg::ST_IDLE;
                    oe_q    <= 1'b0;
                end
            endcase
        end
    end

    // Successive approximation and serial data, advanced by rising edges only
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            sdo_q  <= 1'b0;
            code_q <= sap_pkg::SAR_INIT;
        end
        else if (start)
        begin
            sdo_q  <= 1'b0;
            code_q <= sap_pkg::SAR_INIT;
        end
        else if ((state_q == sap_pkg::ST_CONV) && sclk_rise)
        begin
            if ((cnt_q >= (sap_pkg::EDGE_MSB - 5'h01)) && (cnt_q < sap_pkg::EDGE_SUB0))
            begin
                sdo_q <= cmp_s_q[1];
                code_q[bit_index(cnt_q + 5'h01)] <= cmp_s_q[1];
                if (bit_index(cnt_q + 5'h01) != 4'h0)
                begin
                    code_q[bit_index(cnt_q + 5'h01) - 4'h1] <= 1'b1;
                end
            end
            else
            begin
                sdo_q <= 1'b0;
            end
        end
    end

    // Track/hold: tracks from power-up, holds at start, tracks again at edge 14
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            track_q <= 1'b1;
        end
        else if (start)
        begin
            track_q <= 1'b0;
        end
        else if ((state_q == sap_pkg::ST_CONV) && sclk_rise
                 && (cnt_q == sap_pkg::EDGE_TRACK - 5'h01))
        begin
            track_q <= 1'b1;
        end
    end

    // Power-down modes; a wake frame leaves them without calibration
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            pd_q <= sap_pkg::PD_NONE;
        end
        else if (pd_entry)
        begin
            pd_q <= (pd_q == sap_pkg::PD_NONE) ? sap_pkg::PD_PARTIAL : sap_pkg::PD_FULL;
        end
        else if (pd_exit)
        begin
            pd_q <= sap_pkg::PD_NONE;
        end
    end

    // Result capture; the first result after reset is tagged as calibration
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            push_valid_q <= 1'b0;
            push_data_q  <= '0;
            first_q      <= 1'b1;
            overrun_q    <= 1'b0;
        end
        else
        begin
            push_valid_q <= 1'b0;
            if ((state_q == sap_pkg::ST_CONV) && sclk_rise && (cnt_q == sap_pkg::EDGE_SUB0))
            begin
                push_valid_q <= 1'b1;
                push_data_q  <= {first_q, code_q};
                first_q      <= 1'b0;
            end
            if (push_valid_q && !fif.push_ready)
            begin
                overrun_q <= 1'b1;
            end
        end
    end

    // Acquisition time monitor between tracking and the next start
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            acq_cnt_q   <= sap_pkg::ACQ_CYC_W;
            acq_short_q <= 1'b0;
        end
        else
        begin
            acq_short_q <= start && (acq_cnt_q < sap_pkg::ACQ_CYC_W);
            if (!track_q)
            begin
                acq_cnt_q <= 6'h00;
            end
            else if (acq_cnt_q < sap_pkg::ACQ_CYC_W)
            begin
                acq_cnt_q <= acq_cnt_q + 6'h01;
            end
        end
    end

    // Registered result output stage
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            res_valid_q <= 1'b0;
            res_data_q  <= '0;
        end
        else if (!res_valid_q || result_ready_i)
        begin
            res_valid_q <= fif.pop_valid;
            res_data_q  <= fif.pop_data;
        end
    end

    assign fif.push_valid = push_valid_q;
    assign fif.push_data  = push_data_q;
    assign fif.pop_ready  = !res_valid_q || result_ready_i;

    assign sdo_o          = sdo_q;
    assign sdo_oe         = oe_q;
    assign track_o        = track_q;
    assign dac_code_o     = code_q;
    assign pd_partial_o   = pd_q[0];
    assign pd_full_o      = pd_q[1];
    assign acq_short_o    = acq_short_q;
    assign overrun_o      = overrun_q;
    assign result_valid_o = res_valid_q;
    assign result_data_o  = res_data_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_start_hold;
        start |=> !track_q && sdo_oe && !sdo_o;
    endproperty
    a_start_hold: assert property (p_start_hold) else $error("start did not hold and drive low");

    property p_change_on_rise;
        $changed(sdo_q) |-> $past(sclk_rise) || $past(start);
    endproperty
    a_change_on_rise: assert property (p_change_on_rise) else $error("output moved off edge");

    property p_msb_edge4;
        (state_q == sap_pkg::ST_CONV) && sclk_rise && (cnt_q == (sap_pkg::EDGE_MSB - 5'h01))
            |=> (sdo_q == $past(cmp_s_q[1])) && (cnt_q == sap_pkg::EDGE_MSB);
    endproperty
    a_msb_edge4: assert property (p_msb_edge4) else $error("msb not at fourth edge");

    property p_track_edge14;
        (state_q == sap_pkg::ST_CONV) && sclk_rise
            && (cnt_q == (sap_pkg::EDGE_TRACK - 5'h01)) |=> track_q;
    endproperty
    a_track_edge14: assert property (p_track_edge14) else $error("no tracking at edge 14");

    property p_trail_zero;
        (state_q == sap_pkg::ST_CONV) && sclk_rise && (cnt_q == sap_pkg::EDGE_SUB0)
            |=> !sdo_q && (state_q == sap_pkg::ST_DONE) && push_valid_q;
    endproperty
    a_trail_zero: assert property (p_trail_zero) else $error("frame end wrong");

    property p_release;
        (state_q == sap_pkg::ST_DONE) && rel_pend_q && sclk_rise && !cnv_fall |=> !sdo_oe;
    endproperty
    a_release: assert property (p_release) else $error("output not released");

    property p_idle_hiz;
        (state_q == sap_pkg::ST_IDLE) && !$past(start) |-> !sdo_oe;
    endproperty
    a_idle_hiz: assert property (p_idle_hiz) else $error("output driven while idle");

    property p_continuous;
        (state_q == sap_pkg::ST_CONV) && cnv_rise && (cnt_q >= sap_pkg::EDGE_TRACK)
            |=> sdo_oe [*2];
    endproperty
    a_continuous: assert property (p_continuous) else $error("continuous output dropped");

    property p_pd_partial;
        pd_entry && (pd_q == sap_pkg::PD_NONE) |=> pd_partial_o && !sdo_oe;
    endproperty
    a_pd_partial: assert property (p_pd_partial) else $error("no partial power-down");

    property p_pd_full;
        pd_entry && (pd_q == sap_pkg::PD_PARTIAL) |=> pd_full_o;
    endproperty
    a_pd_full: assert property (p_pd_full) else $error("no full power-down");

    property p_wake;
        pd_exit && (pd_q != sap_pkg::PD_NONE) |=> !pd_partial_o && !pd_full_o;
    endproperty
    a_wake: assert property (p_wake) else $error("power-down not left");
endmodule
`default_nettype wire

/* File: verification/sap_host_model.sv */
// Host-side stand-in: serial clock, convert start and comparator decisions
`timescale 1ns/10ps
`default_nettype none
module sap_host_model
(
    input  wire logic clk_sys,
    input  wire logic sdo_o,
    input  wire logic sdo_oe,
    input  wire logic track_o,
    output logic      sclk_i,
    output logic      conv_start_n,
    output logic      cmp_i
);
    logic line_q;
    logic line;

    // A released data line shows the inverse of its last level
    assign line = sdo_oe ? sdo_o : ~line_q;

    always_ff @(posedge clk_sys)
    begin
        line_q <= line;
    end

    initial
    begin
        sclk_i = 1'b0;
        conv_start_n = 1'b1;
        cmp_i = 1'b0;
    end

    // Runs rises clock edges; start goes high after edge up, or after the frame if up is 0
    task automatic frame(input int rises, input int up, input logic [11:0] code,
                         input int gap, output logic [15:0] dat,
                         output logic [15:0] oe, output logic [15:0] trk);
        dat = '0;
        oe = '0;
        trk = '0;
        @(posedge clk_sys);
        conv_start_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        for (int k = 1; k <= rises; k++)
        begin
            @(posedge clk_sys);
            cmp_i <= (k >= 4 && k <= 15) ? code[15-k] : 1'b0;
            repeat (3) @(posedge clk_sys);
            sclk_i <= 1'b1;
            repeat (4) @(posedge clk_sys);
            if (k == up)
                conv_start_n <= 1'b1;
            sclk_i <= 1'b0;
            repeat (3) @(posedge clk_sys);
            @(negedge clk_sys);
            dat[16-k] = line;
            oe[16-k] = sdo_oe;
            trk[16-k] = track_o;
        end
        @(posedge clk_sys);
        conv_start_n <= 1'b1;
        repeat (gap) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

/* File: verification/tb_sap_port.sv */
// Self-checking bench of the serial conversion port
`timescale 1ns/10ps
`default_nettype none
module tb_sap_port;
    typedef struct packed
    {
        logic [11:0] code;
        logic [3:0]  up;
        logic        calib;
        logic        oe_end;
    } sap_row_t;

    localparam sap_row_t ROWS [5] = '{'{12'hA5C, 4'hF, 1'b1, 1'b1},
        '{12'hFFF, 4'hF, 1'b0, 1'b1}, '{12'h000, 4'h0, 1'b0, 1'b0},
        '{12'h3C3, 4'h0, 1'b0, 1'b0}, '{12'h801, 4'hF, 1'b0, 1'b1}};

    logic                       clk_sys;
    logic                       reset;
    logic                       sclk_i;
    logic                       conv_start_n;
    logic                       cmp_i;
    logic                       sdo_o;
    logic                       sdo_oe;
    logic                       track_o;
    logic [sap_pkg::RES_W-1:0]  dac_code_o;
    logic                       pd_partial_o;
    logic                       pd_full_o;
    logic                       acq_short_o;
    logic                       overrun_o;
    logic                       result_valid_o;
    logic [sap_pkg::FIFO_W-1:0] result_data_o;
    logic                       result_ready_i;
    logic [15:0]                dat;
    logic [15:0]                oe;
    logic [15:0]                trk;
    logic [12:0]                word;
    int                         err_total = 0;
    int                         cmp_count = 0;
    int                         short_cnt = 0;
    int                         s0;

    sap_port dut_u
    (
        .clk_sys        (clk_sys),
        .reset          (reset),
        .sclk_i         (sclk_i),
        .conv_start_n   (conv_start_n),
        .cmp_i          (cmp_i),
        .sdo_o          (sdo_o),
        .sdo_oe         (sdo_oe),
        .track_o        (track_o),
        .dac_code_o     (dac_code_o),
        .pd_partial_o   (pd_partial_o),
        .pd_full_o      (pd_full_o),
        .acq_short_o    (acq_short_o),
        .overrun_o      (overrun_o),
        .result_valid_o (result_valid_o),
        .result_data_o  (result_data_o),
        .result_ready_i (result_ready_i)
    );

    sap_host_model host_u
    (
        .clk_sys      (clk_sys),
        .sdo_o        (sdo_o),
        .sdo_oe       (sdo_oe),
        .track_o      (track_o),
        .sclk_i       (sclk_i),
        .conv_start_n (conv_start_n),
        .cmp_i        (cmp_i)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        if (acq_short_o === 1'b1)
            short_cnt <= short_cnt + 1;
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk_frame(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_res(input logic [12:0] got, input logic [12:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Takes one result word; the transfer lands on the edge after valid is seen
    task automatic pop(output logic [12:0] w);
        int n;
        n = 0;
        result_ready_i <= 1'b1;
        @(negedge clk_sys);
        while (result_valid_o !== 1'b1 && n < 100)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 100)
        begin
            err_total++;
            results();
        end
        w = result_data_o;
        @(posedge clk_sys);
        result_ready_i <= 1'b0;
    endtask

    task automatic conv(input int rises, input int up, input logic [11:0] code, input int gap);
        host_u.frame(rises, up, code, gap, dat, oe, trk);
    endtask

    initial
    begin
        reset = 1'b1;
        result_ready_i = 1'b0;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk_flag(track_o, 1'b1);
        chk_flag(sdo_oe, 1'b0);
        for (int i = 0; i < 5; i++)
        begin
            conv(16, ROWS[i].up, ROWS[i].code, 40);
            chk_frame(dat, {3'h0, ROWS[i].code, 1'b0});
            chk_frame(oe, 16'hFFFF);
            chk_frame(trk, 16'h0007);
            chk_flag(sdo_oe, ROWS[i].oe_end);
            chk_res({1'b0, dac_code_o}, {1'b0, ROWS[i].code});
            pop(word);
            chk_res(word, {ROWS[i].calib, ROWS[i].code});
            $display("row %0d done", i);
        end
        conv(2, 2, 12'h000, 40);
        chk_flag(sdo_oe, 1'b0);
        chk_flag(pd_partial_o, 1'b0);
        chk_flag(result_valid_o, 1'b0);
        $display("abort test done");
        conv(5, 5, 12'h000, 40);
        chk_flag(pd_partial_o, 1'b1);
        chk_flag(sdo_oe, 1'b0);
        conv(5, 5, 12'h000, 40);
        chk_flag(pd_full_o, 1'b1);
        conv(16, 15, 12'h5A6, 40);
        chk_frame(dat, {3'h0, 12'h5A6, 1'b0});
        chk_flag(pd_full_o, 1'b0);
        chk_flag(pd_partial_o, 1'b0);
        pop(word);
        chk_res(word, {1'b0, 12'h5A6});
        $display("power-down test done");
        s0 = short_cnt;
        conv(16, 15, 12'h111, 0);
        conv(16, 15, 12'h222, 40);
        chk_flag(1'(short_cnt == s0 + 1), 1'b1);
        pop(word);
        chk_res(word, {1'b0, 12'h111});
        @(posedge clk_sys);
        pop(word);
        chk_res(word, {1'b0, 12'h222});
        $display("short acquisition test done");
        for (int i = 0; i < 10; i++)
            conv(16, 15, 12'h100 + 12'(i), 40);
        chk_flag(overrun_o, 1'b1);
        for (int i = 0; i < 9; i++)
        begin
            pop(word);
            chk_res(word, {1'b0, 12'h100 + 12'(i)});
            @(posedge clk_sys);
        end
        repeat (4) @(posedge clk_sys);
        chk_flag(result_valid_o, 1'b0);
        $display("buffer test done");
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk_flag(track_o, 1'b1);
        chk_flag(sdo_oe, 1'b0);
        chk_flag(overrun_o, 1'b0);
        chk_flag(pd_full_o, 1'b0);
        @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        conv(16, 0, 12'h3A5, 40);
        pop(word);
        chk_res(word, {1'b1, 12'h3A5});
        $display("reset test done");
        results();
    end
endmodule
`default_nettype wire
